// [bench/calendar_clock_control_test.sv]
// Purpose: self-checking bench for the calendar clock control block
// Assumes: APB slave may insert any number of wait states, presetn is power-on reset
// Notes: pulses are counted at the falling edge, where registered outputs have settled
module calendar_clock_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [calendar_pkg::ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic wse = 1'b0, idle_mode = 1'b0, osc_running = 1'b0, rollover_window = 1'b0;
    logic half_tick = 1'b0, seconds_written = 1'b0, timebase_pulse = 1'b0, minute_tick = 1'b0;
    logic seconds_clock = 1'b0, alarm_pulse = 1'b0;
    logic corrected_pulse, bus_clock_gate_off, module_enable, calendar_pin_out, calendar_pin_oe;
    logic [31:0] rdata;
    logic err;
    int fail_count = 0;
    int n_tests = 0;

    calendar_clock_control calendar_clock_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .write_seq_enabled(wse), .idle_mode(idle_mode),
        .osc_running(osc_running), .rollover_window(rollover_window), .half_tick(half_tick),
        .seconds_written(seconds_written), .timebase_pulse(timebase_pulse), .minute_tick(minute_tick),
        .seconds_clock(seconds_clock), .alarm_pulse(alarm_pulse), .corrected_pulse(corrected_pulse),
        .bus_clock_gate_off(bus_clock_gate_off), .module_enable(module_enable),
        .calendar_pin_out(calendar_pin_out), .calendar_pin_oe(calendar_pin_oe));

    initial
    begin
        forever #25 pclk = ~pclk;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask

    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // flops are read right after the edge, before their updates land, so we see what that edge sampled
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task expect_base(input string what, input logic [31:0] exp);
        apb(1'b0, calendar_pkg::OFF_BASE, 32'h0000_0000);
        check(what, rdata, exp);
    endtask

    // ends on a rising edge so the next stimulus is driven there
    task settle;
        repeat (3) @(posedge pclk);
    endtask

    task t_access;
        expect_base("reset value", 32'h0000_0000);
        check("outputs after reset", {module_enable, calendar_pin_oe, bus_clock_gate_off}, 32'h0);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        check("unmapped error", err, 32'h1);
        expect_base("unmapped write", 32'h0000_0000);
        apb(1'b1, calendar_pkg::OFF_BASE, 32'h0000_0008);
        expect_base("unlock while closed", 32'h0000_0000);
        wse <= 1'b1;
        apb(1'b1, calendar_pkg::OFF_BASE, 32'h0000_8008);
        expect_base("enable while locked", 32'h0000_0008);
        apb(1'b1, calendar_pkg::OFF_BASE, 32'h0000_8008);
        expect_base("enable while unlocked", 32'h0000_8008);
        check("module enable", module_enable, 32'h1);
        apb(1'b1, calendar_pkg::OFF_BASE, 32'hFFFF_FFFF);
        expect_base("all ones written", 32'h03FF_A089);
        apb(1'b1, calendar_pkg::OFF_CLR, 32'h0000_2001);
        expect_base("clear alias", 32'h03FF_8088);
        apb(1'b1, calendar_pkg::OFF_SET, 32'h0000_0001);
        expect_base("set alias", 32'h03FF_8089);
        apb(1'b1, calendar_pkg::OFF_INV, 32'h0000_0081);
        expect_base("invert alias", 32'h03FF_8008);
    endtask

    task t_pins;
        apb(1'b1, calendar_pkg::OFF_SET, 32'h0000_2081);
        seconds_clock <= 1'b1;
        idle_mode <= 1'b1;
        settle();
        check("pin seconds", {calendar_pin_out, calendar_pin_oe}, 32'h3);
        check("gate in idle", bus_clock_gate_off, 32'h1);
        apb(1'b1, calendar_pkg::OFF_CLR, 32'h0000_2080);
        settle();
        check("pin alarm low", calendar_pin_out, 32'h0);
        check("gate halt clear", bus_clock_gate_off, 32'h0);
        alarm_pulse <= 1'b1;
        settle();
        check("pin alarm high", calendar_pin_out, 32'h1);
        apb(1'b1, calendar_pkg::OFF_CLR, 32'h0000_0001);
        settle();
        check("pin disabled", {calendar_pin_out, calendar_pin_oe}, 32'h0);
        idle_mode <= 1'b0;
    endtask

    task t_status;
        osc_running <= 1'b1;
        rollover_window <= 1'b1;
        @(posedge pclk);
        half_tick <= 1'b1;
        @(posedge pclk);
        half_tick <= 1'b0;
        settle();
        expect_base("status set", 32'h03FF_804E);
        apb(1'b1, calendar_pkg::OFF_CLR, 32'h0000_0046);
        expect_base("status write ignored", 32'h03FF_804E);
        @(posedge pclk);
        seconds_written <= 1'b1;
        osc_running <= 1'b0;
        @(posedge pclk);
        seconds_written <= 1'b0;
        settle();
        expect_base("status clear", 32'h03FF_800C);
        rollover_window <= 1'b0;
    endtask

    // clearing enable mid-burst stops the inserted pulses; one idle cycle follows the clear
    task t_abort;
        apb(1'b1, calendar_pkg::OFF_BASE, 32'h01FF_8008);
        minute_tick <= 1'b1;
        @(posedge pclk);
        minute_tick <= 1'b0;
        repeat (4) @(posedge pclk);
        check("burst running", corrected_pulse, 32'h1);
        apb(1'b1, calendar_pkg::OFF_CLR, 32'h0000_8000);
        @(posedge pclk);
        settle();
        check("abort pulse", {corrected_pulse, module_enable}, 32'h0);
        expect_base("enable cleared", 32'h01FF_0008);
    endtask

    // n_in raw pulses every other cycle; result is the corrected pulse count over the window
    task t_trim(input logic [9:0] cal, input int n_in);
        int cnt;
        int s;
        cnt = 0;
        s = cal[9] ? int'(cal) - 1024 : int'(cal);
        apb(1'b1, calendar_pkg::OFF_BASE, {6'h00, cal, 16'h8008});
        expect_base("trim field", {6'h00, cal, 16'h8008});
        @(posedge pclk);
        minute_tick <= 1'b1;
        for (int i = 0; i < 2 * n_in + 530; i++)
        begin
            @(posedge pclk);
            minute_tick <= 1'b0;
            timebase_pulse <= (i >= 2) && (i < 2 + 2 * n_in) && (i % 2 == 0);
            @(negedge pclk);
            if (corrected_pulse === 1'b1)
                cnt++;
        end
        check("trim pulse count", cnt, n_in + s);
    endtask

    task t_reset_again;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        expect_base("after second reset", 32'h0000_0000);
        check("enable after reset", module_enable, 32'h0);
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        conclude();
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_access();
        t_pins();
        t_status();
        t_trim(10'h003, 0);
        t_trim(10'h1FF, 0);
        t_trim(10'h000, 6);
        t_trim(10'h3FF, 4);
        t_trim(10'h3FE, 5);
        t_trim(10'h200, 520);
        t_abort();
        t_reset_again();
        conclude();
    end
endmodule

// [rtl/calendar_clock_control.sv]
// Purpose: control register, drift trim engine and pin routing of the calendar clock
// Assumes: presetn is the power-on reset; time counters and unlock sequence live outside
// Notes: APB slave with one wait state; aliases at +4 clear, +8 set, +C invert
//
// What this block does
// - drift trim is a signed 10-bit value in control bits 25 to 16
// - positive trim N inserts N time-base pulses each minute, at most 511
// - negative trim removes pulses each minute; all ones one, most negative 512
// - zero trim leaves the time-base pulse stream untouched
// - control bit 15 enables the calendar clock module
// - enable bit accepts writes only while write-unlock is set
// - idle-halt bit 13 gates the bus clock off while the chip idles
// - bit 7 picks seconds clock when set, alarm pulse when clear, for the pin
// - pin is driven only while pin output enable bit 0 is set
// - read-only bit 6 shows whether the time base is running
// - write-unlock bit 3 can be set only while the write sequence is open
// - half-second flag bit 1 is read-only, cleared by a seconds write
// - control register is reset by power-on reset only
// - bits 31 to 26, 14 and 12 to 8 always read zero
// - clear, set and invert aliases change only bits written as one
module calendar_clock_control
(
    input wire logic pclk, // bus clock, 20 MHz
    input wire logic presetn, // power-on reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [calendar_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb transfer done
    output logic pslverr, // apb unmapped address
    input wire logic write_seq_enabled, // system write sequence is open
    input wire logic idle_mode, // chip is in idle mode
    input wire logic osc_running, // time-base oscillator alive
    input wire logic rollover_window, // counters about to roll over
    input wire logic half_tick, // time base crossed a half second
    input wire logic seconds_written, // software wrote the seconds fields
    input wire logic timebase_pulse, // raw time-base pulse
    input wire logic minute_tick, // one pulse per minute
    input wire logic seconds_clock, // seconds clock from the counters
    input wire logic alarm_pulse, // alarm pulse from the counters
    output logic corrected_pulse, // trimmed time-base pulse
    output logic bus_clock_gate_off, // request to stop the bus clock
    output logic module_enable, // module enable to the counters
    output logic calendar_pin_out, // pin level
    output logic calendar_pin_oe // pin output enable
);

    logic [calendar_pkg::CAL_W-1:0] cal_q;
    logic enable_q;
    logic idle_halt_q;
    logic pin_sel_q;
    logic unlock_q;
    logic pin_oe_q;
    logic running_q;
    logic sync_q;
    logic half_q;
    logic [calendar_pkg::CAL_W-1:0] remain_q;
    calendar_pkg::cal_state_t cal_state_q;
    logic [31:0] ctrl_word;
    logic [31:0] new_word;
    logic access;
    logic wr_fire;
    logic mapped;
    logic insert;
    logic swallow;

    // true for the base register and its three aliases
    function automatic logic is_mapped(input logic [calendar_pkg::ADDR_W-1:0] a);
        return a == calendar_pkg::OFF_BASE || a == calendar_pkg::OFF_CLR ||
            a == calendar_pkg::OFF_SET || a == calendar_pkg::OFF_INV;
    endfunction

    // word that a write at this offset leaves behind
    function automatic logic [31:0] merge(input logic [calendar_pkg::ADDR_W-1:0] a,
        input logic [31:0] cur, input logic [31:0] w);
        logic [31:0] r;
        r = w;
        if (a == calendar_pkg::OFF_CLR)
        begin
            r = cur & ~w;
        end
        else if (a == calendar_pkg::OFF_SET)
        begin
            r = cur | w;
        end
        else if (a == calendar_pkg::OFF_INV)
        begin
            r = cur ^ w;
        end
        return r;
    endfunction

    always_comb
    begin
        ctrl_word = calendar_pkg::READ_ZERO;
        ctrl_word[calendar_pkg::BIT_CAL_HI:calendar_pkg::BIT_CAL_LO] = cal_q;
        ctrl_word[calendar_pkg::BIT_ENABLE] = enable_q;
        ctrl_word[calendar_pkg::BIT_IDLE_HALT] = idle_halt_q;
        ctrl_word[calendar_pkg::BIT_PIN_SEL] = pin_sel_q;
        ctrl_word[calendar_pkg::BIT_RUNNING] = running_q;
        ctrl_word[calendar_pkg::BIT_UNLOCK] = unlock_q;
        ctrl_word[calendar_pkg::BIT_SYNC] = sync_q;
        ctrl_word[calendar_pkg::BIT_HALF] = half_q;
        ctrl_word[calendar_pkg::BIT_PIN_OE] = pin_oe_q;
    end

    assign access = psel && penable;
    assign mapped = is_mapped(paddr);
    // a write lands only at the edge where pready is seen high
    assign wr_fire = access && pready && pwrite && mapped;
    assign new_word = merge(paddr, ctrl_word, pwdata);

    // one wait state keeps pready and prdata straight from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= calendar_pkg::READ_ZERO;
        end
        else
        begin
            pready <= access && !pready;
            pslverr <= access && !pready && !mapped;
            if (access && !pready && !pwrite && paddr == calendar_pkg::OFF_BASE)
            begin
                prdata <= ctrl_word;
            end
            else
            begin
                prdata <= calendar_pkg::READ_ZERO;
            end
        end
    end

    // only presetn clears the register; no other reset source reaches it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_q <= calendar_pkg::CAL_RESET;
            enable_q <= calendar_pkg::CONTROL_RESET[calendar_pkg::BIT_ENABLE];
            idle_halt_q <= calendar_pkg::CONTROL_RESET[calendar_pkg::BIT_IDLE_HALT];
            pin_sel_q <= calendar_pkg::CONTROL_RESET[calendar_pkg::BIT_PIN_SEL];
            unlock_q <= calendar_pkg::CONTROL_RESET[calendar_pkg::BIT_UNLOCK];
            pin_oe_q <= calendar_pkg::CONTROL_RESET[calendar_pkg::BIT_PIN_OE];
        end
        else if (wr_fire)
        begin
            // read-only and unused positions of new_word are simply not stored
            cal_q <= new_word[calendar_pkg::BIT_CAL_HI:calendar_pkg::BIT_CAL_LO];
            idle_halt_q <= new_word[calendar_pkg::BIT_IDLE_HALT];
            pin_sel_q <= new_word[calendar_pkg::BIT_PIN_SEL];
            pin_oe_q <= new_word[calendar_pkg::BIT_PIN_OE];
            if (unlock_q)
            begin
                enable_q <= new_word[calendar_pkg::BIT_ENABLE];
            end
            if (!new_word[calendar_pkg::BIT_UNLOCK] || write_seq_enabled)
            begin
                unlock_q <= new_word[calendar_pkg::BIT_UNLOCK];
            end
        end
    end

    // status flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            running_q <= 1'b0;
            sync_q <= 1'b0;
            half_q <= 1'b0;
        end
        else
        begin
            running_q <= enable_q && osc_running;
            sync_q <= enable_q && rollover_window;
            // a half tick in the same cycle as a seconds write still wins
            if (half_tick)
            begin
                half_q <= !half_q || seconds_written;
            end
            else if (seconds_written)
            begin
                half_q <= 1'b0;
            end
        end
    end

    // drift trim engine: one burst per minute, new minute ticks ignored while busy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_state_q <= calendar_pkg::CAL_IDLE;
            remain_q <= calendar_pkg::CAL_RESET;
        end
        else if (!enable_q)
        begin
            cal_state_q <= calendar_pkg::CAL_IDLE;
            remain_q <= calendar_pkg::CAL_RESET;
        end
        else
        begin
            unique case (cal_state_q)
                calendar_pkg::CAL_IDLE:
                begin
                    if (minute_tick && cal_q != calendar_pkg::CAL_RESET)
                    begin
                        if (cal_q[calendar_pkg::CAL_W-1])
                        begin
                            cal_state_q <= calendar_pkg::CAL_SUB;
                            remain_q <= calendar_pkg::CAL_W'(-cal_q);
                        end
                        else
                        begin
                            cal_state_q <= calendar_pkg::CAL_ADD;
                            remain_q <= cal_q;
                        end
                    end
                end
                calendar_pkg::CAL_ADD,
                calendar_pkg::CAL_SUB:
                begin
                    if (insert || swallow)
                    begin
                        remain_q <= remain_q - calendar_pkg::REMAIN_ONE;
                        if (remain_q == calendar_pkg::REMAIN_ONE)
                        begin
                            cal_state_q <= calendar_pkg::CAL_IDLE;
                        end
                    end
                end
                default:
                begin
                    cal_state_q <= calendar_pkg::CAL_IDLE;
                end
            endcase
        end
    end

    // extra pulses go only into gaps of the raw stream so none merge
    assign insert = cal_state_q == calendar_pkg::CAL_ADD && !timebase_pulse;
    assign swallow = cal_state_q == calendar_pkg::CAL_SUB && timebase_pulse;

    // outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            corrected_pulse <= 1'b0;
            bus_clock_gate_off <= 1'b0;
            module_enable <= 1'b0;
            calendar_pin_out <= 1'b0;
            calendar_pin_oe <= 1'b0;
        end
        else
        begin
            corrected_pulse <= enable_q && ((timebase_pulse && !swallow) || insert);
            bus_clock_gate_off <= idle_halt_q && idle_mode;
            module_enable <= enable_q;
            calendar_pin_out <= pin_oe_q && (pin_sel_q ? seconds_clock : alarm_pulse);
            calendar_pin_oe <= pin_oe_q;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_enable_locked: assert property (wr_fire && !unlock_q |=> enable_q == $past(enable_q))
        else $error("enable changed while locked");
    a_unlock_gate: assert property (wr_fire && !write_seq_enabled && !unlock_q |=> !unlock_q)
        else $error("unlock set without write sequence");
    a_half_clear: assert property (seconds_written && !half_tick |=> !half_q)
        else $error("half-second flag survived seconds write");
    a_pin_quiet: assert property (!pin_oe_q |=> !calendar_pin_out && !calendar_pin_oe)
        else $error("pin driven without output enable");
    a_pin_source: assert property (pin_oe_q && pin_sel_q |=> calendar_pin_out == $past(seconds_clock))
        else $error("pin not following seconds clock");
    a_idle_gate: assert property (idle_halt_q && idle_mode |=> bus_clock_gate_off)
        else $error("bus clock not gated in idle");
    a_reserved_zero: assert property (pready && !pwrite |-> prdata[31:26] == 6'h00 && !prdata[14]
        && prdata[12:8] == 5'h00)
        else $error("unused control bits read nonzero");
    a_sub_swallow: assert property (enable_q && swallow |=> !corrected_pulse)
        else $error("pulse not removed during negative trim");
    a_add_load: assert property (enable_q && cal_state_q == calendar_pkg::CAL_IDLE && minute_tick
        && cal_q != 10'h000 && !cal_q[9] |=> cal_state_q == calendar_pkg::CAL_ADD && remain_q == $past(cal_q))
        else $error("positive trim not loaded");
    a_zero_trim: assert property (cal_state_q == calendar_pkg::CAL_IDLE && cal_q == 10'h000
        |=> cal_state_q == calendar_pkg::CAL_IDLE)
        else $error("correction started with zero trim");
    a_apb_wait: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");

    c_add_burst: cover property (cal_state_q == calendar_pkg::CAL_ADD ##1 cal_state_q == calendar_pkg::CAL_IDLE);
    c_sub_burst: cover property (cal_state_q == calendar_pkg::CAL_SUB ##1 cal_state_q == calendar_pkg::CAL_IDLE);
    c_alias_write: cover property (wr_fire && paddr == calendar_pkg::OFF_INV);
    c_unlocked_enable: cover property (wr_fire && unlock_q && new_word[15]);

endmodule

// [rtl/calendar_pkg.sv]
// Purpose: shared constants and types for the calendar clock control block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: the base register and its three aliases share one decode
package calendar_pkg;
    localparam int ADDR_W = 8;
    localparam int CAL_W = 10;
    localparam logic [ADDR_W-1:0] OFF_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CLR = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_SET = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_INV = 8'h0C;
    localparam int BIT_CAL_LO = 16;
    localparam int BIT_CAL_HI = 25;
    localparam int BIT_ENABLE = 15;
    localparam int BIT_IDLE_HALT = 13;
    localparam int BIT_PIN_SEL = 7;
    localparam int BIT_RUNNING = 6;
    localparam int BIT_UNLOCK = 3;
    localparam int BIT_SYNC = 2;
    localparam int BIT_HALF = 1;
    localparam int BIT_PIN_OE = 0;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [CAL_W-1:0] CAL_RESET = 10'h000;
    localparam logic [CAL_W-1:0] REMAIN_ONE = 10'h001;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    typedef enum logic [1:0]
    {
        CAL_IDLE = 2'b00,
        CAL_ADD = 2'b01,
        CAL_SUB = 2'b10
    } cal_state_t;
endpackage
